// [pwmu_gate_drv.sv]
// gate driver model of the power stage, counting shoot-through cycles
`timescale 1ns/10ps
`default_nettype none
module pwmu_gate_drv (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // gate commands, two switches per leg
    input  wire logic [5:0] gate_cmd,
    // observation
    output var  int         shoot
);
    // both switches of one leg on together would short the supply
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            shoot <= 0;
        end else begin
            for (int g = 0; g < 3; g++) begin
                if (gate_cmd[2*g] === 1'b1 && gate_cmd[2*g+1] === 1'b1) begin
                    shoot <= shoot + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [pwmu_map.svh]
// register map and field positions of the pwm unit
// =====================================================================
// Notes on behaviour
// - three generators, each with a 16-bit down or up/down timer and two comparators
// - down mode: count from load value to zero, reload, keep counting down
// - up/down mode: count zero up to load, back down to zero, repeat
// - direction output low in down mode, follows count direction in up/down mode
// - one-cycle pulses at zero and at load; in down mode load follows zero
// - each comparator pulses for one cycle when count equals its match value
// - in up/down mode matches split into up-match and down-match by direction
// - a match value above the load value never produces a match pulse
// - output logic acts on four events in down mode, six in up/down mode
// - a match coinciding with a zero or load event is ignored
// - on coincident A and B matches, output A sees only A, output B only B
// - per event and output: keep, toggle, drive low or drive high
// - dead-band off passes both; on, output A is input A with delayed rise
// - dead-band on, output B is inverted input A with its rise delayed separately
// - generator interrupt raised by any event of a software-selected subset
// - adc trigger pulse from any event of a second independent subset
// - interrupt and trigger use raw counter events, ignoring dead-band delays
// - global reset clears the counters of any selected set of generators together
// - immediate mode: new load or match value takes effect at next zero
// - synchronous mode: new value waits for global update, then next zero
// - per-output fault enable forces the output inactive while fault is active
// - debugger stall: either run to zero and halt, or keep counting
// - one output-enable setting selects which of the six signals reach the pins
// - per-output inversion makes a final output active low
`ifndef PWMU_MAP_SVH
`define PWMU_MAP_SVH
// =====================================================================
// global registers, byte offsets
`define PWMU_O_CTL     8'h00
`define PWMU_O_SYNC    8'h04
`define PWMU_O_ENABLE  8'h08
`define PWMU_O_INVERT  8'h0c
`define PWMU_O_FAULT   8'h10
`define PWMU_O_INTEN   8'h14
`define PWMU_O_RIS     8'h18
`define PWMU_O_ISC     8'h1c
`define PWMU_O_STATUS  8'h20
// =====================================================================
// generator registers, offset inside a 64-byte generator window
`define PWMU_G_CTL     6'h00
`define PWMU_G_INTEN   6'h04
`define PWMU_G_RIS     6'h08
`define PWMU_G_ISC     6'h0c
`define PWMU_G_LOAD    6'h10
`define PWMU_G_COUNT   6'h14
`define PWMU_G_CMPA    6'h18
`define PWMU_G_CMPB    6'h1c
`define PWMU_G_GENA    6'h20
`define PWMU_G_GENB    6'h24
`define PWMU_G_DBCTL   6'h28
`define PWMU_G_DBRISE  6'h2c
`define PWMU_G_DBFALL  6'h30
// =====================================================================
// fields
`define PWMU_GCTL_EN      0
`define PWMU_GCTL_UPDN    1
`define PWMU_GCTL_LDSYNC  2
`define PWMU_GCTL_CMPSYNC 3
`define PWMU_GCTL_DBGRUN  4
`define PWMU_TRIG_LSB     8
`define PWMU_FLT_INT_BIT  16
`define PWMU_EV_ZERO      0
`define PWMU_EV_LOAD      1
`define PWMU_EV_AUP       2
`define PWMU_EV_ADN       3
`define PWMU_EV_BUP       4
`define PWMU_EV_BDN       5
`endif

// [pwmu_pkg.sv]
// types shared by the pwm unit
`default_nettype none
package pwmu_pkg;
    typedef enum logic [1:0] {
        PWMU_ACT_KEEP   = 2'h0,
        PWMU_ACT_TOGGLE = 2'h1,
        PWMU_ACT_LOW    = 2'h2,
        PWMU_ACT_HIGH   = 2'h3
    } pwmu_act_t;
    typedef enum logic {PWMU_DIR_DOWN, PWMU_DIR_UP} pwmu_dir_t;
endpackage
`default_nettype wire

// [pwmu_top.sv]
// three-generator pwm unit with dead-band, fault forcing and output control
`timescale 1ns/10ps
`default_nettype none
`include "pwmu_map.svh"
module pwmu_top import pwmu_pkg::*; #(
    parameter int NGEN = 3,
    parameter int CW   = 16,
    parameter int DBW  = 12,
    parameter int NEV  = 6
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // external conditions
    input  wire logic                fault_pin,
    input  wire logic                debug_stall,
    // outputs
    output logic      [2*NGEN-1:0]   pwm_out,
    output logic      [NGEN-1:0]     gen_irq,
    output logic                     fault_irq,
    output logic      [NGEN-1:0]     adc_trigger
);
    localparam int NO = 2 * NGEN;

    // =================================================================
    // helpers
    function automatic logic apply_act(input logic cur, input logic [1:0] act);
        case (pwmu_act_t'(act))
            PWMU_ACT_TOGGLE: apply_act = ~cur;
            PWMU_ACT_LOW:    apply_act = 1'b0;
            PWMU_ACT_HIGH:   apply_act = 1'b1;
            default:         apply_act = cur;
        endcase
    endfunction

    // own matches win over the other comparator on coincidence
    function automatic logic next_level(input logic cur, input logic [2*NEV-1:0] act,
                                        input logic [NEV-1:0] ev, input logic first);
        logic v;
        int   own_up;
        int   oth_up;
        v      = cur;
        own_up = first ? `PWMU_EV_AUP : `PWMU_EV_BUP;
        oth_up = first ? `PWMU_EV_BUP : `PWMU_EV_AUP;
        if (ev[`PWMU_EV_ZERO]) v = apply_act(v, act[2*`PWMU_EV_ZERO +: 2]);
        if (ev[`PWMU_EV_LOAD]) v = apply_act(v, act[2*`PWMU_EV_LOAD +: 2]);
        if (ev[own_up] | ev[own_up+1]) begin
            for (int e = own_up; e <= own_up + 1; e++) begin
                if (ev[e]) v = apply_act(v, act[2*e +: 2]);
            end
        end else begin
            for (int e = oth_up; e <= oth_up + 1; e++) begin
                if (ev[e]) v = apply_act(v, act[2*e +: 2]);
            end
        end
        next_level = v;
    endfunction

    // =================================================================
    // address decode
    logic [1:0] blk;
    logic [5:0] boff;
    logic       glob_sel;
    assign blk      = reg_addr[7:6];
    assign boff     = reg_addr[5:0];
    assign glob_sel = (blk == 2'h0);

    // =================================================================
    // fault pin synchroniser: a change counts once stages two and three agree
    logic [2:0] flt_sync;
    logic       fault_act;
    always_ff @(posedge ref_clk) begin
        if (reset) flt_sync <= 3'h0;
        else       flt_sync <= {flt_sync[1:0], fault_pin};
    end
    always_ff @(posedge ref_clk) begin
        if (reset)                        fault_act <= 1'b0;
        else if (flt_sync[1] == flt_sync[2]) fault_act <= flt_sync[2];
    end

    // =================================================================
    // global registers
    logic [NO-1:0]   out_en;
    logic [NO-1:0]   out_inv;
    logic [NO-1:0]   flt_en;
    logic [NGEN-1:0] gint_en;
    logic            fint_en;
    logic            fint_ris;
    logic            glob_upd;
    logic [NGEN-1:0] sync_rst;
    logic            wr_g;

    assign wr_g     = reg_wr & glob_sel;
    assign glob_upd = wr_g & (reg_addr == `PWMU_O_CTL) & reg_wdata[0];
    assign sync_rst = (wr_g & (reg_addr == `PWMU_O_SYNC)) ? reg_wdata[NGEN-1:0] : '0;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_en  <= '0;
            out_inv <= '0;
            flt_en  <= '0;
            gint_en <= '0;
            fint_en <= 1'b0;
        end else if (wr_g) begin
            if (reg_addr == `PWMU_O_ENABLE) out_en  <= reg_wdata[NO-1:0];
            if (reg_addr == `PWMU_O_INVERT) out_inv <= reg_wdata[NO-1:0];
            if (reg_addr == `PWMU_O_FAULT)  flt_en  <= reg_wdata[NO-1:0];
            if (reg_addr == `PWMU_O_INTEN) begin
                gint_en <= reg_wdata[NGEN-1:0];
                fint_en <= reg_wdata[`PWMU_FLT_INT_BIT];
            end
        end
    end

    // sticky fault flag; a fault in the clearing cycle keeps it set
    always_ff @(posedge ref_clk) begin
        if (reset)          fint_ris <= 1'b0;
        else if (fault_act) fint_ris <= 1'b1;
        else if (wr_g && reg_addr == `PWMU_O_ISC && reg_wdata[`PWMU_FLT_INT_BIT])
            fint_ris <= 1'b0;
    end
    assign fault_irq = fint_ris & fint_en;

    // =================================================================
    // generator blocks
    logic [NGEN-1:0][CW-1:0]  cnt_v;
    logic [NGEN-1:0][31:0]    grd_v;
    logic [NGEN-1:0][NEV-1:0] gris_v;
    logic [NO-1:0]            raw_out;

    for (genvar g = 0; g < NGEN; g++) begin : g_gen
        logic [7:0]      ctl;
        logic [15:0]     inten;
        logic [NEV-1:0]  ris;
        logic [CW-1:0]   load_sh, cmpa_sh, cmpb_sh;
        logic [CW-1:0]   load_ac, cmpa_ac, cmpb_ac;
        logic [2*NEV-1:0] act_a, act_b;
        logic            db_on;
        logic [DBW-1:0]  db_rise, db_fall, rcnt, fcnt;
        logic            ld_arm, cmp_arm;
        logic [CW-1:0]   cnt;
        pwmu_dir_t       dir;
        logic            gen_a, gen_b, db_a, db_b, trig;
        logic            wr_b, en, updn, is_zero, is_load, hit_a, hit_b, halt;
        logic            take_ld, take_cmp;
        logic [CW-1:0]   next_load;
        logic [NEV-1:0]  ev;

        assign wr_b = reg_wr & (blk == 2'(g + 1));
        assign en   = ctl[`PWMU_GCTL_EN];
        assign updn = ctl[`PWMU_GCTL_UPDN];

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                ctl <= '0; inten <= '0; load_sh <= '0; cmpa_sh <= '0; cmpb_sh <= '0;
                act_a <= '0; act_b <= '0; db_on <= 1'b0; db_rise <= '0; db_fall <= '0;
            end else if (wr_b) begin
                case (boff)
                    `PWMU_G_CTL:    ctl     <= reg_wdata[7:0];
                    `PWMU_G_INTEN:  inten   <= reg_wdata[15:0];
                    `PWMU_G_LOAD:   load_sh <= reg_wdata[CW-1:0];
                    `PWMU_G_CMPA:   cmpa_sh <= reg_wdata[CW-1:0];
                    `PWMU_G_CMPB:   cmpb_sh <= reg_wdata[CW-1:0];
                    `PWMU_G_GENA:   act_a   <= reg_wdata[2*NEV-1:0];
                    `PWMU_G_GENB:   act_b   <= reg_wdata[2*NEV-1:0];
                    `PWMU_G_DBCTL:  db_on   <= reg_wdata[0];
                    `PWMU_G_DBRISE: db_rise <= reg_wdata[DBW-1:0];
                    `PWMU_G_DBFALL: db_fall <= reg_wdata[DBW-1:0];
                    default: ;
                endcase
            end
        end

        // shadow values move to the active set only at a counter zero
        assign is_zero  = en & (cnt == '0);
        assign take_ld  = is_zero & (~ctl[`PWMU_GCTL_LDSYNC] | ld_arm);
        assign take_cmp = is_zero & (~ctl[`PWMU_GCTL_CMPSYNC] | cmp_arm);
        assign next_load = take_ld ? load_sh : load_ac;

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                ld_arm <= 1'b0;
                cmp_arm <= 1'b0;
            end else begin
                if (glob_upd)     ld_arm <= 1'b1;
                else if (take_ld) ld_arm <= 1'b0;
                if (glob_upd)      cmp_arm <= 1'b1;
                else if (take_cmp) cmp_arm <= 1'b0;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                load_ac <= '0; cmpa_ac <= '0; cmpb_ac <= '0;
            end else begin
                if (take_ld) load_ac <= load_sh;
                if (take_cmp) begin
                    cmpa_ac <= cmpa_sh;
                    cmpb_ac <= cmpb_sh;
                end
            end
        end

        // stall without run-on: count to zero and stay there
        assign halt = debug_stall & ~ctl[`PWMU_GCTL_DBGRUN] & (cnt == '0);

        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt <= '0;
                dir <= PWMU_DIR_DOWN;
            end else if (!en) begin
                cnt <= '0;
                dir <= updn ? PWMU_DIR_UP : PWMU_DIR_DOWN;
            end else if (sync_rst[g]) begin
                cnt <= '0;
                dir <= updn ? PWMU_DIR_UP : PWMU_DIR_DOWN;
            end else if (halt) begin
                cnt <= cnt;
            end else if (!updn) begin
                dir <= PWMU_DIR_DOWN;
                cnt <= (cnt == '0) ? next_load : cnt - 1'b1;
            end else if (dir == PWMU_DIR_UP) begin
                if (cnt >= load_ac) begin
                    dir <= PWMU_DIR_DOWN;
                    cnt <= (cnt == '0) ? cnt : cnt - 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end else if (cnt == '0) begin
                dir <= PWMU_DIR_UP;
                cnt <= (next_load == '0) ? cnt : cnt + 1'b1;
            end else begin
                cnt <= cnt - 1'b1;
            end
        end

        // raw events
        assign is_load = en & (cnt == load_ac);
        assign hit_a = en & (cnt == cmpa_ac) & (cmpa_ac <= load_ac);
        assign hit_b = en & (cnt == cmpb_ac) & (cmpb_ac <= load_ac);
        always_comb begin
            ev = '0;
            ev[`PWMU_EV_ZERO] = is_zero;
            ev[`PWMU_EV_LOAD] = is_load;
            if (!(is_zero | is_load)) begin
                ev[`PWMU_EV_AUP] = hit_a & (dir == PWMU_DIR_UP);
                ev[`PWMU_EV_ADN] = hit_a & (dir == PWMU_DIR_DOWN);
                ev[`PWMU_EV_BUP] = hit_b & (dir == PWMU_DIR_UP);
                ev[`PWMU_EV_BDN] = hit_b & (dir == PWMU_DIR_DOWN);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (reset || !en) begin
                gen_a <= 1'b0;
                gen_b <= 1'b0;
            end else begin
                gen_a <= next_level(gen_a, act_a, ev, 1'b1);
                gen_b <= next_level(gen_b, act_b, ev, 1'b0);
            end
        end

        // dead band: falling edges pass at once, rising edges wait their count
        always_ff @(posedge ref_clk) begin
            if (reset || !gen_a) begin
                rcnt <= '0;
                db_a <= 1'b0;
            end else if (rcnt >= db_rise) begin
                db_a <= 1'b1;
            end else begin
                rcnt <= rcnt + 1'b1;
            end
        end
        always_ff @(posedge ref_clk) begin
            if (reset || gen_a) begin
                fcnt <= '0;
                db_b <= 1'b0;
            end else if (fcnt >= db_fall) begin
                db_b <= 1'b1;
            end else begin
                fcnt <= fcnt + 1'b1;
            end
        end
        assign raw_out[2*g]   = db_on ? db_a : gen_a;
        assign raw_out[2*g+1] = db_on ? db_b : gen_b;

        // interrupt and trigger from raw events; an event beats a clear
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                ris  <= '0;
                trig <= 1'b0;
            end else begin
                trig <= |(ev & inten[`PWMU_TRIG_LSB +: NEV]);
                if (wr_b && boff == `PWMU_G_ISC)
                    ris <= (ris & ~reg_wdata[NEV-1:0]) | (ev & inten[NEV-1:0]);
                else
                    ris <= ris | (ev & inten[NEV-1:0]);
            end
        end
        assign adc_trigger[g] = trig;
        assign gen_irq[g]     = gint_en[g] & (|ris);
        assign cnt_v[g]       = cnt;
        assign gris_v[g]      = ris;

        always_comb begin
            case (boff)
                `PWMU_G_CTL:    grd_v[g] = 32'(ctl);
                `PWMU_G_INTEN:  grd_v[g] = 32'(inten);
                `PWMU_G_RIS:    grd_v[g] = 32'(ris);
                `PWMU_G_ISC:    grd_v[g] = 32'(ris);
                `PWMU_G_LOAD:   grd_v[g] = 32'(load_sh);
                `PWMU_G_COUNT:  grd_v[g] = 32'(cnt);
                `PWMU_G_CMPA:   grd_v[g] = 32'(cmpa_sh);
                `PWMU_G_CMPB:   grd_v[g] = 32'(cmpb_sh);
                `PWMU_G_GENA:   grd_v[g] = 32'(act_a);
                `PWMU_G_GENB:   grd_v[g] = 32'(act_b);
                `PWMU_G_DBCTL:  grd_v[g] = 32'(db_on);
                `PWMU_G_DBRISE: grd_v[g] = 32'(db_rise);
                `PWMU_G_DBFALL: grd_v[g] = 32'(db_fall);
                default:        grd_v[g] = 32'h0;
            endcase
        end

        // assertions
        a_down_reload: assert property (@(posedge ref_clk) disable iff (reset)
            en && !updn && is_zero && !halt && !sync_rst[g] && $stable(ctl)
            |=> cnt == $past(next_load))
            else $error("down counter did not reload at zero");
        a_dir_low: assert property (@(posedge ref_clk) disable iff (reset)
            en && !updn && $past(en && !updn) |-> dir == PWMU_DIR_DOWN)
            else $error("direction not low in down mode");
        a_match_cap: assert property (@(posedge ref_clk) disable iff (reset)
            cmpa_ac > load_ac |-> !ev[`PWMU_EV_AUP] && !ev[`PWMU_EV_ADN])
            else $error("match beyond load value fired");
        a_match_mask: assert property (@(posedge ref_clk) disable iff (reset)
            (is_zero || is_load) |-> ev[`PWMU_EV_BDN:`PWMU_EV_AUP] == '0)
            else $error("match not masked by zero or load");
        a_trig_cause: assert property (@(posedge ref_clk) disable iff (reset)
            trig |-> $past(|(ev & inten[`PWMU_TRIG_LSB +: NEV])))
            else $error("trigger without selected event");
        sequence s_halted;
            debug_stall && !ctl[`PWMU_GCTL_DBGRUN] && en && cnt == '0 && !sync_rst[g];
        endsequence
        a_stall_halt: assert property (@(posedge ref_clk) disable iff (reset)
            s_halted ##1 (debug_stall && en) |-> cnt == '0)
            else $error("counter moved while halted by stall");
        sequence s_rise;
            !gen_a ##1 gen_a;
        endsequence
        a_db_rise: assert property (@(posedge ref_clk) disable iff (reset)
            s_rise ##0 (db_rise != '0 && $stable(db_rise)) |-> !db_a [*2])
            else $error("dead band rise came too early");
        a_db_overlap: assert property (@(posedge ref_clk) disable iff (reset)
            !(db_a && db_b))
            else $error("both dead band outputs high");
    end

    // =================================================================
    // output control: enable, fault forcing to low, then inversion
    logic [NO-1:0] next_out;
    assign next_out = (raw_out & out_en & ~(flt_en & {NO{fault_act}})) ^ out_inv;
    always_ff @(posedge ref_clk) begin
        if (reset) pwm_out <= '0;
        else       pwm_out <= next_out;
    end

    a_fault_force: assert property (@(posedge ref_clk) disable iff (reset)
        fault_act ##1 fault_act |-> (pwm_out & $past(flt_en)) == ($past(out_inv) & $past(flt_en)))
        else $error("faulted output not forced inactive");

    // =================================================================
    // register read, data valid the cycle after the strobe only
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0;
        if (!glob_sel) begin
            next_rdata = grd_v[blk - 2'h1];
        end else begin
            case (reg_addr)
                `PWMU_O_ENABLE: next_rdata = 32'(out_en);
                `PWMU_O_INVERT: next_rdata = 32'(out_inv);
                `PWMU_O_FAULT:  next_rdata = 32'(flt_en);
                `PWMU_O_INTEN:  next_rdata = 32'(gint_en) | (32'(fint_en) << `PWMU_FLT_INT_BIT);
                `PWMU_O_RIS: begin
                    for (int i = 0; i < NGEN; i++) next_rdata[i] = |gris_v[i];
                    next_rdata[`PWMU_FLT_INT_BIT] = fint_ris;
                end
                `PWMU_O_ISC: begin
                    for (int i = 0; i < NGEN; i++) next_rdata[i] = gen_irq[i];
                    next_rdata[`PWMU_FLT_INT_BIT] = fault_irq;
                end
                `PWMU_O_STATUS: next_rdata = 32'(fault_act);
                default:        next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) reg_rdata <= 32'h0;
        else       reg_rdata <= reg_rd ? next_rdata : 32'h0;
    end
endmodule
`default_nettype wire

// [three_generator_pwm_unit_tb.sv]
// self-checking bench of the three-generator pwm unit
`timescale 1ns/10ps
`default_nettype none
module three_generator_pwm_unit_tb;
    logic        ref_clk, reset, reg_wr, reg_rd, fault_pin, debug_stall, fault_irq;
    logic [7:0]  reg_addr, obs;
    logic [31:0] reg_wdata, reg_rdata, rd_val;
    logic [5:0]  pwm_out;
    logic [2:0]  gen_irq, adc_trigger;
    int          n_errors = 0, n_compared = 0, hits, shoot;
    // address, write data, expected read back
    logic [71:0] rows [6] = '{{8'h50, 32'h0001_2345, 32'h2345}, {8'h6c, 32'hffff_ffff, 32'hfff},
        {8'h08, 32'hffff_ffff, 32'h3f}, {8'h94, 32'h55, 32'h0}, {8'h3c, 32'hffff_ffff, 32'h0},
        {8'h00, 32'h1, 32'h0}};
    // bit 7 flags the A outputs of generators 0 and 1 disagreeing, bit 6 the trigger of generator 0
    assign obs = {pwm_out[0] ^ pwm_out[2], adc_trigger[0], pwm_out};
    pwmu_top dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_pin(fault_pin),
        .debug_stall(debug_stall), .pwm_out(pwm_out), .gen_irq(gen_irq),
        .fault_irq(fault_irq), .adc_trigger(adc_trigger));
    pwmu_gate_drv bridge (.ref_clk(ref_clk), .reset(reset), .gate_cmd(pwm_out), .shoot(shoot));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // ===================================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #10;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #10 rd_val = reg_rdata;
    endtask
    // window lengths are whole periods except in the last check, so the count does not depend on phase
    task automatic meas(input int b, input int cyc);
        hits = 0;
        repeat (cyc) begin
            @(posedge ref_clk);
            #10 hits += (obs[b] === 1'b1);
            if (obs[b] !== 1'b0 && obs[b] !== 1'b1) n_errors++;
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ===================================================================
    // sequence
    initial begin
        {reset, reg_wr, reg_rd, reg_addr, reg_wdata, fault_pin, debug_stall} = '0;
        reset = 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        #10 chk(pwm_out, 0);
        foreach (rows[i]) begin
            wr(rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64]);
            chk(rd_val, rows[i][31:0]);
        end
        wr(8'h50, 32'h4);
        wr(8'h58, 32'h2);
        wr(8'h60, 32'h83);
        wr(8'h6c, 32'h1);
        wr(8'h44, 32'h101);
        wr(8'h14, 32'h10000);
        wr(8'h40, 32'h1);
        repeat (20) @(posedge ref_clk);
        meas(0, 50);
        chk(hits, 30);
        meas(6, 50);
        chk(hits, 10);
        chk(gen_irq, 0);
        wr(8'h14, 32'h10001);
        chk(gen_irq, 1);
        wr(8'h0c, 32'h1);
        meas(0, 50);
        chk(hits, 20);
        @(posedge ref_clk);
        fault_pin <= 1'b1;
        wr(8'h10, 32'h1);
        repeat (10) @(posedge ref_clk);
        meas(0, 20);
        chk(hits, 20);
        chk(fault_irq, 1);
        @(posedge ref_clk);
        fault_pin <= 1'b0;
        wr(8'h0c, 32'h0);
        wr(8'h08, 32'h3e);
        meas(0, 20);
        chk(hits, 0);
        wr(8'h08, 32'h3f);
        @(posedge ref_clk);
        debug_stall <= 1'b1;
        repeat (20) @(posedge ref_clk);
        meas(0, 20);
        chk(hits, 20);
        wr(8'h40, 32'h11);
        repeat (10) @(posedge ref_clk);
        meas(0, 50);
        chk(hits, 30);
        @(posedge ref_clk);
        debug_stall <= 1'b0;
        wr(8'h58, 32'h7);
        wr(8'h60, 32'hc2);
        repeat (20) @(posedge ref_clk);
        meas(0, 50);
        chk(hits, 0);
        wr(8'h58, 32'h4);
        wr(8'h60, 32'h83);
        repeat (20) @(posedge ref_clk);
        meas(0, 50);
        chk(hits, 50);
        wr(8'h58, 32'h2);
        wr(8'h60, 32'hb0);
        wr(8'h40, 32'h3);
        repeat (30) @(posedge ref_clk);
        meas(0, 80);
        chk(hits, 40);
        wr(8'h70, 32'h1);
        wr(8'h68, 32'h1);
        repeat (30) @(posedge ref_clk);
        meas(0, 80);
        chk(hits, 30);
        meas(1, 80);
        chk(hits, 30);
        chk(shoot, 0);
        wr(8'h68, 32'h0);
        wr(8'h90, 32'h4);
        wr(8'h98, 32'h2);
        wr(8'ha0, 32'hb0);
        wr(8'h80, 32'h7);
        wr(8'h04, 32'h3);
        repeat (10) @(posedge ref_clk);
        meas(7, 40);
        chk(hits, 0);
        wr(8'h90, 32'h6);
        repeat (30) @(posedge ref_clk);
        meas(7, 40);
        chk(hits, 0);
        wr(8'h00, 32'h1);
        repeat (30) @(posedge ref_clk);
        meas(7, 40);
        chk(hits == 0, 0);
        wrap_up;
    end
    // the sequence needs about 1050 cycles; allow well over three times that
    initial begin
        #400000;
        n_errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
